// ### acr_pkg.sv
// package for the channel configuration and calibration register bank
package acr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CONFIG      = 8'h22;
  localparam logic [7:0]  IDX_OFS_HIGH    = 8'h23;
  localparam logic [7:0]  IDX_OFS_LOW     = 8'h24;
  localparam logic [7:0]  IDX_GAIN_HIGH   = 8'h25;
  localparam logic [7:0]  IDX_GAIN_LOW    = 8'h26;
  localparam int          ADDR_W          = 10;
  // reset values
  localparam logic [15:0] RST_CONFIG      = 16'h0000;
  localparam logic [15:0] RST_OFS_HIGH    = 16'h0000;
  localparam logic [7:0]  RST_OFS_LOW     = 8'h00;
  localparam logic [15:0] RST_GAIN_HIGH   = 16'h8000;
  localparam logic [7:0]  RST_GAIN_LOW    = 8'h00;
  // field positions in the configuration word
  localparam int          PHASE_LSB       = 6;
  localparam int          PHASE_MSB       = 15;
  localparam int          BYPASS_BIT      = 2;
  localparam int          SEL_LSB         = 0;
  localparam int          SEL_MSB         = 1;
  localparam logic [15:0] CONFIG_WMASK    = 16'hFFC7;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OK         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    ACR_IN_NORMAL,
    ACR_IN_SHORTED,
    ACR_IN_TEST_POS,
    ACR_IN_TEST_NEG
  } acr_input_e;

  // channel settings handed to the datapath
  typedef struct packed {
    logic [9:0]  phase_delay;
    logic        dc_block_bypass;
    acr_input_e  input_select;
    logic [23:0] offset_cal;
    logic [23:0] gain_cal;
  } acr_chan_s;
endpackage : acr_pkg

// ### acr_regs.sv
// channel configuration and calibration register bank on an Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module acr_regs
  import acr_pkg::*;
(
  input  wire logic              core_clk_i,      // 40 MHz clock
  input  wire logic              rst_i,           // async reset, active high
  input  wire logic              clk_en_i,        // freezes all state when low
  input  wire logic [ADDR_W-1:0] avs_address_i,   // byte address
  input  wire logic              avs_read_i,      // read request
  input  wire logic              avs_write_i,     // write request
  input  wire logic [3:0]        avs_byteenable_i, // byte lanes
  input  wire logic [31:0]       avs_writedata_i, // write data
  output logic      [31:0]       avs_readdata_o,  // read data
  output logic                   avs_waitrequest_o, // stall
  output logic      [1:0]        avs_response_o,  // ok or slave error
  output acr_chan_s              chan_o           // applied channel settings
);

  // true when an address hits this bank's index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction : hit

  logic [15:0] config_ff, nxt_config;
  logic [15:0] ofs_high_ff, nxt_ofs_high;
  logic [7:0]  ofs_low_ff, nxt_ofs_low;
  logic [15:0] gain_high_ff, nxt_gain_high;
  logic [7:0]  gain_low_ff, nxt_gain_low;
  logic [1:0]  ofs_seen_ff, nxt_ofs_seen;   // [1] high written, [0] low written
  logic [1:0]  gain_seen_ff, nxt_gain_seen;
  logic        ack_ff, nxt_ack;
  logic        wait_ff, nxt_wait;                // waitrequest straight from a flop
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  resp_ff, nxt_resp;
  acr_chan_s   chan_ff, nxt_chan;
  logic [15:0] wd;
  logic [15:0] wm;
  logic        req;
  logic        mapped;

  assign wd  = avs_writedata_i[15:0];
  assign wm  = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign req = (avs_read_i || avs_write_i) && !ack_ff;

  // register writes, read mux and one-wait-state answer
  always_comb begin
    nxt_config    = config_ff;
    nxt_ofs_high  = ofs_high_ff;
    nxt_ofs_low   = ofs_low_ff;
    nxt_gain_high = gain_high_ff;
    nxt_gain_low  = gain_low_ff;
    nxt_ofs_seen  = ofs_seen_ff;
    nxt_gain_seen = gain_seen_ff;
    nxt_chan      = chan_ff;
    nxt_ack       = req;
    nxt_rdata     = UNMAPPED_DATA;
    nxt_resp      = RESP_OK;
    nxt_wait      = !req;
    // a correction is applied only once both halves are fresh; a write in
    // the same cycle sets its flag again afterwards, so it is never lost
    if (ofs_seen_ff == 2'h3) begin
      nxt_chan.offset_cal = {ofs_high_ff, ofs_low_ff};
      nxt_ofs_seen        = 2'h0;
    end
    if (gain_seen_ff == 2'h3) begin
      nxt_chan.gain_cal = {gain_high_ff, gain_low_ff};
      nxt_gain_seen     = 2'h0;
    end
    mapped = hit(avs_address_i, IDX_CONFIG) || hit(avs_address_i, IDX_OFS_HIGH) ||
             hit(avs_address_i, IDX_OFS_LOW) || hit(avs_address_i, IDX_GAIN_HIGH) ||
             hit(avs_address_i, IDX_GAIN_LOW);
    if (req && !mapped) begin
      nxt_resp = RESP_SLVERR;
    end
    if (req && avs_write_i) begin
      if (hit(avs_address_i, IDX_CONFIG)) begin
        // bits 5:3 never stored
        nxt_config = (config_ff & ~(wm & CONFIG_WMASK)) | (wd & wm & CONFIG_WMASK);
      end
      if (hit(avs_address_i, IDX_OFS_HIGH)) begin
        nxt_ofs_high    = (ofs_high_ff & ~wm) | (wd & wm);
        nxt_ofs_seen[1] = 1'b1;
      end
      if (hit(avs_address_i, IDX_OFS_LOW) && avs_byteenable_i[1]) begin
        nxt_ofs_low     = wd[15:8];
        nxt_ofs_seen[0] = 1'b1;
      end
      if (hit(avs_address_i, IDX_GAIN_HIGH)) begin
        nxt_gain_high    = (gain_high_ff & ~wm) | (wd & wm);
        nxt_gain_seen[1] = 1'b1;
      end
      if (hit(avs_address_i, IDX_GAIN_LOW) && avs_byteenable_i[1]) begin
        nxt_gain_low     = wd[15:8];
        nxt_gain_seen[0] = 1'b1;
      end
    end
    if (req && avs_read_i) begin
      if (hit(avs_address_i, IDX_CONFIG)) begin
        nxt_rdata = {16'h0000, config_ff & CONFIG_WMASK};
      end
      if (hit(avs_address_i, IDX_OFS_HIGH)) begin
        nxt_rdata = {16'h0000, ofs_high_ff};
      end
      if (hit(avs_address_i, IDX_OFS_LOW)) begin
        nxt_rdata = {16'h0000, ofs_low_ff, 8'h00};
      end
      if (hit(avs_address_i, IDX_GAIN_HIGH)) begin
        nxt_rdata = {16'h0000, gain_high_ff};
      end
      if (hit(avs_address_i, IDX_GAIN_LOW)) begin
        nxt_rdata = {16'h0000, gain_low_ff, 8'h00};
      end
    end
    // configuration fields take effect one cycle after the write
    nxt_chan.phase_delay     = config_ff[PHASE_MSB:PHASE_LSB];
    nxt_chan.dc_block_bypass = config_ff[BYPASS_BIT];
    nxt_chan.input_select    = acr_input_e'(config_ff[SEL_MSB:SEL_LSB]);
  end

  // state registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      config_ff                <= RST_CONFIG;
      ofs_high_ff              <= RST_OFS_HIGH;
      ofs_low_ff               <= RST_OFS_LOW;
      gain_high_ff             <= RST_GAIN_HIGH;
      gain_low_ff              <= RST_GAIN_LOW;
      ofs_seen_ff              <= 2'h0;
      gain_seen_ff             <= 2'h0;
      ack_ff                   <= 1'b0;
      wait_ff                  <= 1'b1;
      rdata_ff                 <= UNMAPPED_DATA;
      resp_ff                  <= RESP_OK;
      chan_ff.phase_delay      <= RST_CONFIG[PHASE_MSB:PHASE_LSB];
      chan_ff.dc_block_bypass  <= RST_CONFIG[BYPASS_BIT];
      chan_ff.input_select     <= ACR_IN_NORMAL;
      chan_ff.offset_cal       <= {RST_OFS_HIGH, RST_OFS_LOW};
      chan_ff.gain_cal         <= {RST_GAIN_HIGH, RST_GAIN_LOW};
    end else if (clk_en_i) begin
      config_ff    <= nxt_config;
      ofs_high_ff  <= nxt_ofs_high;
      ofs_low_ff   <= nxt_ofs_low;
      gain_high_ff <= nxt_gain_high;
      gain_low_ff  <= nxt_gain_low;
      ofs_seen_ff  <= nxt_ofs_seen;
      gain_seen_ff <= nxt_gain_seen;
      ack_ff       <= nxt_ack;
      wait_ff      <= nxt_wait;
      rdata_ff     <= nxt_rdata;
      resp_ff      <= nxt_resp;
      chan_ff      <= nxt_chan;
    end
  end

  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign avs_response_o    = resp_ff;
  assign chan_o            = chan_ff;

  // a taken request is answered after one wait state
  wait_answer_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req |=> !avs_waitrequest_o)
    else $error("request not answered");
  // waitrequest is low for one cycle only
  wait_single_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  // no request, no answer
  idle_wait_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && !req && !ack_ff |=> avs_waitrequest_o)
    else $error("answer without request");
  // upper half of read data is always zero
  upper_zero_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("read data upper half nonzero");
  // unmapped or misaligned access answers with an error
  slverr_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && !mapped |=> avs_response_o == RESP_SLVERR)
    else $error("unmapped access not refused");
  // mapped access answers okay
  resp_ok_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && mapped |=> avs_response_o == RESP_OK)
    else $error("mapped access refused");
  // unmapped write leaves the config, offset high and gain high words alone
  unmapped_write_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && !mapped |=>
    $stable(config_ff) && $stable(ofs_high_ff) && $stable(gain_high_ff))
    else $error("unmapped write changed a register");
  // clock enable low freezes the outputs
  frozen_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    !clk_en_i |=> $stable(chan_o) && $stable(avs_waitrequest_o) && $stable(avs_readdata_o))
    else $error("state moved while frozen");

  // reserved config bits read zero
  reserved_zero_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_CONFIG) |->
    (avs_readdata_o[15:0] & ~CONFIG_WMASK) == 16'h0000)
    else $error("reserved config bits read nonzero");
  // reserved config bits are never stored
  reserved_store_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    (config_ff & ~CONFIG_WMASK) == 16'h0000)
    else $error("reserved config bits stored");
  // full config write lands, masked
  cfg_write_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && hit(avs_address_i, IDX_CONFIG) &&
    avs_byteenable_i[1:0] == 2'h3 |=> config_ff == ($past(avs_writedata_i[15:0]) & CONFIG_WMASK))
    else $error("config word not stored");
  // config read returns the stored word
  cfg_read_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_CONFIG) |->
    avs_readdata_o[15:0] == (config_ff & CONFIG_WMASK))
    else $error("config read mismatch");
  // phase delay follows the config word
  phase_follow_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i |=> chan_o.phase_delay == $past(config_ff[PHASE_MSB:PHASE_LSB]))
    else $error("phase delay not applied");
  // bypass follows the config word
  bypass_follow_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i |=> chan_o.dc_block_bypass == $past(config_ff[BYPASS_BIT]))
    else $error("bypass not applied");
  // input selection follows the config word
  select_follow_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i |=> chan_o.input_select == $past(config_ff[SEL_MSB:SEL_LSB]))
    else $error("input select not applied");

  // offset high word write lands
  ofs_high_write_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && hit(avs_address_i, IDX_OFS_HIGH) &&
    avs_byteenable_i[1:0] == 2'h3 |=> ofs_high_ff == $past(avs_writedata_i[15:0]))
    else $error("offset high word not stored");
  // offset high read returns the stored word
  ofs_high_read_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_OFS_HIGH) |->
    avs_readdata_o[15:0] == ofs_high_ff)
    else $error("offset high read mismatch");
  // offset low byte lands from lane 1
  ofs_low_write_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && hit(avs_address_i, IDX_OFS_LOW) &&
    avs_byteenable_i[1] |=> ofs_low_ff == $past(avs_writedata_i[15:8]))
    else $error("offset low byte not stored");
  // offset low write without lane 1 is ignored
  ofs_lane_skip_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && hit(avs_address_i, IDX_OFS_LOW) &&
    !avs_byteenable_i[1] |=> $stable(ofs_low_ff))
    else $error("offset low byte stored without lane");
  // offset low read returns the stored byte
  ofs_low_read_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_OFS_LOW) |->
    avs_readdata_o[15:8] == ofs_low_ff)
    else $error("offset low read mismatch");
  // offset low word reads zero below the byte
  ofs_low_zero_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_OFS_LOW) |-> avs_readdata_o[7:0] == 8'h00)
    else $error("offset low byte read nonzero");
  // offset correction applied once both halves are written
  ofs_apply_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && ofs_seen_ff == 2'h3 |=>
    chan_o.offset_cal == {$past(ofs_high_ff), $past(ofs_low_ff)})
    else $error("offset correction not applied");
  // offset correction held until the pair is complete
  ofs_hold_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ofs_seen_ff != 2'h3 |=> $stable(chan_o.offset_cal))
    else $error("offset correction changed early");

  // gain high word write lands
  gain_high_write_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && hit(avs_address_i, IDX_GAIN_HIGH) &&
    avs_byteenable_i[1:0] == 2'h3 |=> gain_high_ff == $past(avs_writedata_i[15:0]))
    else $error("gain high word not stored");
  // gain high read returns the stored word
  gain_high_read_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_GAIN_HIGH) |->
    avs_readdata_o[15:0] == gain_high_ff)
    else $error("gain high read mismatch");
  // gain low byte lands from lane 1
  gain_low_write_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && hit(avs_address_i, IDX_GAIN_LOW) &&
    avs_byteenable_i[1] |=> gain_low_ff == $past(avs_writedata_i[15:8]))
    else $error("gain low byte not stored");
  // gain low write without lane 1 is ignored
  gain_lane_skip_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && req && avs_write_i && hit(avs_address_i, IDX_GAIN_LOW) &&
    !avs_byteenable_i[1] |=> $stable(gain_low_ff))
    else $error("gain low byte stored without lane");
  // gain low read returns the stored byte
  gain_low_read_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_GAIN_LOW) |->
    avs_readdata_o[15:8] == gain_low_ff)
    else $error("gain low read mismatch");
  // gain low word reads zero below the byte
  gain_low_zero_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_ff && avs_read_i && hit(avs_address_i, IDX_GAIN_LOW) |-> avs_readdata_o[7:0] == 8'h00)
    else $error("gain low byte read nonzero");
  // gain correction applied once both halves are written
  gain_apply_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && gain_seen_ff == 2'h3 |=>
    chan_o.gain_cal == {$past(gain_high_ff), $past(gain_low_ff)})
    else $error("gain correction not applied");
  // gain correction held until the pair is complete
  gain_hold_a : assert property (@(posedge core_clk_i) disable iff (rst_i)
    gain_seen_ff != 2'h3 |=> $stable(chan_o.gain_cal))
    else $error("gain correction changed early");
endmodule : acr_regs
`default_nettype wire

// ### acr_regs_tb.sv
// self-checking bench for the channel configuration and calibration register bank
`timescale 1ns/100ps
`default_nettype none
module acr_regs_tb
  import acr_pkg::*;
;
  localparam logic [9:0] A_CFG = {IDX_CONFIG, 2'b00};
  localparam logic [9:0] A_OH  = {IDX_OFS_HIGH, 2'b00};
  localparam logic [9:0] A_OL  = {IDX_OFS_LOW, 2'b00};
  localparam logic [9:0] A_GH  = {IDX_GAIN_HIGH, 2'b00};
  localparam logic [9:0] A_GL  = {IDX_GAIN_LOW, 2'b00};
  logic        core_clk_i, rst_i, clk_en_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [9:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [1:0]  avs_response_o, rs;
  logic [15:0] v;
  acr_chan_s   chan_o;
  int          bad_count, num_checks;

  // device under test
  acr_regs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .chan_o(chan_o));

  // 40 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // one bus access: hold until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [15:0] d,
                      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_byteenable_i <= be;
    avs_writedata_i <= {16'h0000, d};
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    rs = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("ERROR waitrequest expected 0 seen stuck");
      report_and_stop();
    end
  endtask : xfer

  task automatic wr_reg(input logic [9:0] a, input logic [15:0] d, input logic [3:0] be,
                        input logic [1:0] er);
    xfer(1'b1, a, d, be);
    check("write response", {30'h0, er}, {30'h0, rs});
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [9:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    xfer(1'b0, a, 16'h0000, 4'hF);
    check(nm, exp, rd);
    check("read response", {30'h0, er}, {30'h0, rs});
  endtask : rd_chk

  task automatic settle;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : settle

  // main sequence
  initial begin
    rst_i = 1'b1; clk_en_i = 1'b1; avs_read_i = 1'b0; avs_write_i = 1'b0;
    avs_address_i = '0; avs_byteenable_i = '0; avs_writedata_i = '0;
    bad_count = 0; num_checks = 0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    check("gain out", 32'h0080_0000, {8'h00, chan_o.gain_cal});
    check("offset out", 32'h0, {8'h00, chan_o.offset_cal});
    rd_chk("config", A_CFG, 32'h0, RESP_OK);
    rd_chk("ofs high", A_OH, 32'h0, RESP_OK);
    rd_chk("ofs low", A_OL, 32'h0, RESP_OK);
    rd_chk("gain high", A_GH, 32'h8000, RESP_OK);
    rd_chk("gain low", A_GL, 32'h0, RESP_OK);
    $display("test reset values done");
    wr_reg(A_CFG, 16'hFFFF, 4'hF, RESP_OK);
    rd_chk("config ro", A_CFG, 32'hFFC7, RESP_OK);
    // every input selection, negative phase boundary, bypass toggled
    for (int s = 0; s < 4; s++) begin
      v = {10'h200 + 10'(s), 3'b000, 1'(s), 2'(s)};
      wr_reg(A_CFG, v, 4'h3, RESP_OK);
      settle();
      check("config out", {19'h0, v[15:6], v[2], v[1:0]}, {19'h0, chan_o.phase_delay,
            chan_o.dc_block_bypass, chan_o.input_select});
    end
    $display("test config done");
    wr_reg(A_OH, 16'h8001, 4'h3, RESP_OK);
    settle();
    check("offset half", 32'h0, {8'h00, chan_o.offset_cal});
    wr_reg(A_OL, 16'hA5FF, 4'h3, RESP_OK);
    rd_chk("ofs low", A_OL, 32'hA500, RESP_OK);
    rd_chk("ofs high", A_OH, 32'h8001, RESP_OK);
    check("offset out", 32'h0080_01A5, {8'h00, chan_o.offset_cal});
    wr_reg(A_GL, 16'h3CFF, 4'h1, RESP_OK);
    rd_chk("gain low lane", A_GL, 32'h0, RESP_OK);
    wr_reg(A_GL, 16'h3CFF, 4'h3, RESP_OK);
    wr_reg(A_GH, 16'hFFFF, 4'h3, RESP_OK);
    rd_chk("gain low", A_GL, 32'h3C00, RESP_OK);
    rd_chk("gain high", A_GH, 32'hFFFF, RESP_OK);
    check("gain out", 32'h00FF_FF3C, {8'h00, chan_o.gain_cal});
    $display("test calibration done");
    wr_reg(10'h09C, 16'h1234, 4'h3, RESP_SLVERR);
    rd_chk("unmapped", 10'h09C, 32'h0, RESP_SLVERR);
    rd_chk("misaligned", 10'h089, 32'h0, RESP_SLVERR);
    rd_chk("gain high kept", A_GH, 32'hFFFF, RESP_OK);
    $display("test unmapped done");
    // clock enable low stalls the bus until it rises again
    clk_en_i <= 1'b0;
    fork
      wr_reg(A_GH, 16'h1234, 4'h3, RESP_OK);
      begin
        repeat (3) @(negedge core_clk_i);
        check("frozen wait", 32'h1, {31'h0, avs_waitrequest_o});
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
      end
    join
    rd_chk("gain high after freeze", A_GH, 32'h1234, RESP_OK);
    $display("test clock enable done");
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_chk("gain high", A_GH, 32'h8000, RESP_OK);
    rd_chk("ofs low", A_OL, 32'h0, RESP_OK);
    rd_chk("gain low", A_GL, 32'h0, RESP_OK);
    check("gain out", 32'h0080_0000, {8'h00, chan_o.gain_cal});
    $display("test second reset done");
    report_and_stop();
  end
endmodule : acr_regs_tb
`default_nettype wire
